/* File: hdl/sbr_map.vh */
// Purpose: constants for the serial bit-rate and receive-flag block
// Assumes: 32-bit AXI4-Lite register window, one aligned word per register
// Notes:   offsets are byte addresses
`ifndef SBR_MAP_VH
`define SBR_MAP_VH

// ============================================================
// register offsets
`define SBR_OFS_STATUS      4'h0
`define SBR_OFS_RATE        4'h4
`define SBR_OFS_DATA        4'h8
`define SBR_ADDR_W          4

// ============================================================
// rate register fields
`define SBR_PRESCALE_HI     6
`define SBR_PRESCALE_LO     4
`define SBR_RATE_HI         2
`define SBR_RATE_LO         0
`define SBR_RATE_RESET      8'h00

// ============================================================
// status register fields
`define SBR_STAT_RXFULL     7

// ============================================================
// transfer timing
`define SBR_XFER_BITS       8
`define SBR_HALF_EDGES      5'h10

// ============================================================
// axi responses
`define SBR_RESP_OKAY       2'h0
`define SBR_RESP_SLVERR     2'h2

`endif

/* File: hdl/sbr_prescale.v */
// Purpose: prescaler, one tick every (code + 1) bus clocks
// Assumes: i_run low holds the counter cleared
// Notes:   code may change at any time; the new value acts on the next compare
`default_nettype none

module sbr_prescale (
  // clock and reset
  input  wire       i_sys_clk,
  input  wire       i_arst_n,
  // control
  input  wire       i_run,
  input  wire [2:0] i_code,
  // output
  output wire       o_tick
);

  reg [2:0] cnt_q;
  reg [2:0] cnt_d;

  // counter reaching the code means code + 1 cycles have passed
  assign o_tick = i_run && (cnt_q >= i_code);

  always @* begin
    cnt_d = cnt_q;
    if (!i_run || o_tick) begin
      cnt_d = 3'h0;
    end else begin
      cnt_d = cnt_q + 3'h1;
    end
  end

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

`default_nettype wire

/* File: hdl/sbr_rate_div.v */
// Purpose: rate divider, half-period pulse every 2^code prescaler ticks
// Assumes: a full shift clock period is two half periods, so 2^(code+1) ticks
// Notes:   counter is cleared while idle so each frame starts in phase
`default_nettype none

module sbr_rate_div (
  // clock and reset
  input  wire       i_sys_clk,
  input  wire       i_arst_n,
  // control
  input  wire       i_run,
  input  wire       i_tick,
  input  wire [2:0] i_code,
  // output
  output wire       o_half
);

  reg  [6:0] cnt_q;
  reg  [6:0] cnt_d;
  wire [6:0] last;

  assign last   = (7'h01 << i_code) - 7'h01;
  // compare with >= so a code lowered mid-count cannot overrun
  assign o_half = i_run && i_tick && (cnt_q >= last);

  always @* begin
    cnt_d = cnt_q;
    if (!i_run || o_half) begin
      cnt_d = 7'h00;
    end else if (i_tick) begin
      cnt_d = cnt_q + 7'h01;
    end
  end

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

`default_nettype wire

/* File: hdl/sbr_top.v */
// Purpose: serial master bit-rate generator with receive-full flag
// Assumes: single 200 MHz bus clock, AXI4-Lite register access, SPI mode 0
// Notes:   writing the data register starts one 8-bit transfer when idle
`include "sbr_map.vh"
`default_nettype none

module sbr_top (
  // clock and reset
  input  wire        i_sys_clk,
  input  wire        i_arst_n,
  // axi4-lite write address
  input  wire        i_s_axi_awvalid,
  output wire        o_s_axi_awready,
  input  wire [3:0]  i_s_axi_awaddr,
  // axi4-lite write data
  input  wire        i_s_axi_wvalid,
  output wire        o_s_axi_wready,
  input  wire [31:0] i_s_axi_wdata,
  input  wire [3:0]  i_s_axi_wstrb,
  // axi4-lite write response
  output wire        o_s_axi_bvalid,
  input  wire        i_s_axi_bready,
  output wire [1:0]  o_s_axi_bresp,
  // axi4-lite read address
  input  wire        i_s_axi_arvalid,
  output wire        o_s_axi_arready,
  input  wire [3:0]  i_s_axi_araddr,
  // axi4-lite read data
  output wire        o_s_axi_rvalid,
  input  wire        i_s_axi_rready,
  output wire [31:0] o_s_axi_rdata,
  output wire [1:0]  o_s_axi_rresp,
  // serial link
  output wire        o_sck,
  output wire        o_mosi,
  input  wire        i_miso,
  output wire        o_busy
);

  // ============================================================
  // registers
  reg        aw_have_q;
  reg [3:0]  aw_addr_q;
  reg        w_have_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;
  reg        bvalid_q;
  reg [1:0]  bresp_q;
  reg        rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0]  rresp_q;

  reg [2:0]  prescale_code_q;
  reg [2:0]  rate_divide_code_q;
  reg        receive_full_flag_q;
  reg        clear_armed_q;
  reg [7:0]  serial_data_buffer_q;

  reg        busy_q;
  reg        sck_q;
  reg        mosi_q;
  reg [7:0]  shift_q;
  reg [4:0]  edge_cnt_q;

  // reset value of the rate register, split into its two fields
  // so each field flop is loaded at exactly its own width
  localparam [7:0] rate_rst     = `SBR_RATE_RESET;
  localparam [2:0] prescale_rst = rate_rst[`SBR_PRESCALE_HI:`SBR_PRESCALE_LO];
  localparam [2:0] divide_rst   = rate_rst[`SBR_RATE_HI:`SBR_RATE_LO];

  // ============================================================
  // write channel
  wire       wr_fire;
  wire       rd_fire;
  wire       wr_status;
  wire       wr_rate;
  wire       wr_data;
  wire       wr_map;
  wire       rd_status;
  wire       rd_data;
  wire       rd_map;

  // each channel is taken once and held until the pair is complete
  assign o_s_axi_awready = !aw_have_q && !bvalid_q;
  assign o_s_axi_wready  = !w_have_q && !bvalid_q;
  assign wr_fire         = aw_have_q && w_have_q && !bvalid_q;

  assign wr_status = (aw_addr_q == `SBR_OFS_STATUS);
  assign wr_rate   = (aw_addr_q == `SBR_OFS_RATE);
  assign wr_data   = (aw_addr_q == `SBR_OFS_DATA);
  assign wr_map    = wr_status || wr_rate || wr_data;

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_have_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `SBR_RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= {i_s_axi_awaddr[3:2], 2'b00};
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= i_s_axi_wdata;
        w_strb_q <= i_s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_map ? `SBR_RESP_OKAY : `SBR_RESP_SLVERR;
      end else if (bvalid_q && i_s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign o_s_axi_bvalid = bvalid_q;
  assign o_s_axi_bresp  = bresp_q;

  // ============================================================
  // read channel
  assign o_s_axi_arready = !rvalid_q;
  assign rd_fire         = i_s_axi_arvalid && !rvalid_q;
  assign rd_status       = ({i_s_axi_araddr[3:2], 2'b00} == `SBR_OFS_STATUS);
  assign rd_data         = ({i_s_axi_araddr[3:2], 2'b00} == `SBR_OFS_DATA);
  assign rd_map          = rd_status || rd_data ||
                           ({i_s_axi_araddr[3:2], 2'b00} == `SBR_OFS_RATE);

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `SBR_RESP_OKAY;
    end else begin
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rresp_q  <= rd_map ? `SBR_RESP_OKAY : `SBR_RESP_SLVERR;
        if (rd_status) begin
          // only the full flag is live; all other bits read zero
          rdata_q <= {24'h00_0000, receive_full_flag_q, 7'h00};
        end else if (rd_data) begin
          rdata_q <= {24'h00_0000, serial_data_buffer_q};
        end else if (rd_map) begin
          // reserved bits 7 and 3 are not stored and read zero
          rdata_q <= {24'h00_0000, 1'b0, prescale_code_q,
                      1'b0, rate_divide_code_q};
        end else begin
          rdata_q <= 32'h0000_0000;
        end
      end else if (rvalid_q && i_s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign o_s_axi_rvalid = rvalid_q;
  assign o_s_axi_rdata  = rdata_q;
  assign o_s_axi_rresp  = rresp_q;

  // ============================================================
  // rate register
  // no busy check: a new rate takes hold at the next divider compare
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prescale_code_q    <= prescale_rst;
      rate_divide_code_q <= divide_rst;
    end else if (wr_fire && wr_rate && w_strb_q[0]) begin
      prescale_code_q    <= w_data_q[`SBR_PRESCALE_HI:`SBR_PRESCALE_LO];
      rate_divide_code_q <= w_data_q[`SBR_RATE_HI:`SBR_RATE_LO];
    end
  end
  // a write at the status offset reaches no flop below: wr_status is
  // only decoded for the response code

  // ============================================================
  // clock generation chain
  wire pre_tick;
  wire half_edge;

  // prescaler runs on the bus clock; its tick drives the rate divider
  sbr_prescale u_prescale (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_run     (busy_q),
    .i_code    (prescale_code_q),
    .o_tick    (pre_tick)
  );

  sbr_rate_div u_rate_div (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_run     (busy_q),
    .i_tick    (pre_tick),
    .i_code    (rate_divide_code_q),
    .o_half    (half_edge)
  );

  // ============================================================
  // shift engine, mode 0, msb first
  wire xfer_start;
  wire xfer_done;

  // data writes while busy are dropped; queueing is not provided here
  assign xfer_start = wr_fire && wr_data && w_strb_q[0] && !busy_q;
  assign xfer_done  = busy_q && half_edge && (edge_cnt_q == `SBR_HALF_EDGES - 5'h01);

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy_q     <= 1'b0;
      sck_q      <= 1'b0;
      mosi_q     <= 1'b0;
      shift_q    <= 8'h00;
      edge_cnt_q <= 5'h00;
    end else if (xfer_start) begin
      busy_q     <= 1'b1;
      sck_q      <= 1'b0;
      shift_q    <= w_data_q[7:0];
      mosi_q     <= w_data_q[7];
      edge_cnt_q <= 5'h00;
    end else if (busy_q && half_edge) begin
      sck_q      <= !sck_q;
      edge_cnt_q <= edge_cnt_q + 5'h01;
      if (!sck_q) begin
        // rising edge samples the slave's bit
        shift_q <= {shift_q[6:0], i_miso};
      end else begin
        mosi_q <= shift_q[7];
      end
      if (xfer_done) begin
        busy_q <= 1'b0;
        mosi_q <= 1'b0;
      end
    end
  end

  assign o_sck  = sck_q;
  assign o_mosi = mosi_q;
  assign o_busy = busy_q;

  // ============================================================
  // receive buffer and full flag
  wire status_seen;
  wire data_take;
  wire flag_clear;
  wire buf_free;

  assign status_seen = rd_fire && rd_status && receive_full_flag_q;
  assign data_take   = rd_fire && rd_data;
  assign flag_clear  = data_take && clear_armed_q;
  // a clearing data read (status seen full first) in this very cycle frees the buffer for new data
  assign buf_free    = !receive_full_flag_q || flag_clear;

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      receive_full_flag_q  <= 1'b0;
      clear_armed_q        <= 1'b0;
      serial_data_buffer_q <= 8'h00;
    end else begin
      if (status_seen) begin
        clear_armed_q <= 1'b1;
      end else if (flag_clear) begin
        clear_armed_q <= 1'b0;
      end
      if (xfer_done && buf_free) begin
        // set wins over a clear in the same cycle
        receive_full_flag_q  <= 1'b1;
        serial_data_buffer_q <= shift_q;
      end else if (flag_clear) begin
        receive_full_flag_q <= 1'b0;
      end
      // a finished byte with the buffer still full is simply dropped
    end
  end

  // the last rising-edge sample lands in shift_q one half period before
  // done, so shift_q already holds the whole received byte

endmodule

`default_nettype wire

/* File: sim/sbr_top_sva.sv */
// Purpose: port checks for sbr_top
// Assumes: one clock domain
// Notes:   flag model follows the read-order clear
`default_nettype none
module sbr_top_sva (
  input wire logic        i_sys_clk,
  input wire logic        i_arst_n,
  input wire logic        i_s_axi_arvalid,
  input wire logic        o_s_axi_arready,
  input wire logic [3:0]  i_s_axi_araddr,
  input wire logic        o_s_axi_rvalid,
  input wire logic        i_s_axi_rready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic        o_sck,
  input wire logic        o_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  // ==========
  // helper state
  logic [3:0]  ra_q;
  logic        full_q, arm_q, sc_q, bz_q;
  logic [4:0]  tg_q;
  logic [11:0] hc_q, h_q;
  wire rs = o_s_axi_rvalid && ra_q[3:2] == 2'h0;
  wire rh = o_s_axi_rvalid && i_s_axi_rready;
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {ra_q, full_q, arm_q, sc_q, bz_q, tg_q, hc_q, h_q} <= '0;
    end else begin
      sc_q <= o_sck;
      bz_q <= o_busy;
      if (i_s_axi_arvalid && o_s_axi_arready) ra_q <= i_s_axi_araddr;
      if (rh && rs && o_s_axi_rdata[7]) arm_q <= 1'b1;
      if (rh && ra_q[3:2] == 2'h2 && arm_q) begin
        arm_q <= 1'b0;
        full_q <= 1'b0;
      end
      // a finishing frame wins over a clear
      if (bz_q && !o_busy) full_q <= 1'b1;
      hc_q <= (o_sck != sc_q) ? 12'h1 : hc_q + 12'h1;
      if (o_sck != sc_q) h_q <= hc_q;
      if (o_busy && !bz_q) tg_q <= 5'h0;
      else if (o_sck != sc_q) tg_q <= tg_q + 5'h1;
    end
  end
  // ==========
  // properties
  property p_idle; !o_busy |-> !o_sck; endproperty
  a_idle: assert property (p_idle) else $error("idle sck");
  property p_zero; rs |-> (o_s_axi_rdata & 32'hFFFFFF4F) == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("status zero bits");
  property p_flag; rs |-> o_s_axi_rdata[7] == full_q; endproperty
  a_flag: assert property (p_flag) else $error("receive flag");
  property p_cnt; bz_q && !o_busy |-> tg_q == 5'hF; endproperty
  a_cnt: assert property (p_cnt) else $error("edge count");
  // interval before the first edge of a frame spans the idle gap, so skip it
  property p_half; o_sck != sc_q && tg_q > 5'h1 |-> hc_q == h_q; endproperty
  a_half: assert property (p_half) else $error("uneven sck");
  property p_ar; i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid; endproperty
  a_ar: assert property (p_ar) else $error("read late");
  property p_hold; o_s_axi_rvalid |-> !o_s_axi_arready; endproperty
  a_hold: assert property (p_hold) else $error("read overlap");
  property p_rone; rh |=> !o_s_axi_rvalid; endproperty
  a_rone: assert property (p_rone) else $error("read repeats");
  c_done: cover property (bz_q && !o_busy);
  c_arm: cover property (rs && o_s_axi_rdata[7]);
  c_lost: cover property (bz_q && !o_busy && full_q);
endmodule
bind sbr_top sbr_top_sva sbr_top_sva_inst (
  .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_s_axi_arvalid(i_s_axi_arvalid),
  .o_s_axi_arready(o_s_axi_arready), .i_s_axi_araddr(i_s_axi_araddr),
  .o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready),
  .o_s_axi_rdata(o_s_axi_rdata), .o_sck(o_sck), .o_busy(o_busy));
`default_nettype wire

/* File: sim/sbr_spi_slave.sv */
// Purpose: serial slave model, mode 0, msb first
// Assumes: no select line, frame marked by busy
// Notes:   miso toggles between frames so stale bits never pass
`default_nettype none
module sbr_spi_slave (
  input  wire logic       i_clk,
  input  wire logic       i_sck,
  input  wire logic       i_mosi,
  input  wire logic       i_busy,
  input  wire logic [7:0] i_tx,
  output logic            o_miso,
  output logic [7:0]      o_rx
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] idx = 3'h7;
  logic       idl = 1'b0;
  // one process owns the bit index; it is back at 7 whenever idle
  always @(negedge i_sck or negedge i_busy) idx <= i_busy ? idx - 3'h1 : 3'h7;
  always @(posedge i_sck) o_rx <= {o_rx[6:0], i_mosi};
  always @(posedge i_clk) idl <= ~idl;
  assign o_miso = i_busy ? i_tx[idx] : idl;
endmodule
`default_nettype wire

/* File: sim/sbr_top_tb_top.sv */
// Purpose: self-checking bench for sbr_top
// Assumes: 200 MHz clock, slave model on the link
// Notes:   every prescale and rate code is run at least once
`include "sbr_map.vh"
`default_nettype none
module sbr_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst_n, awv, wv, bry, arv, rry, miso;
  logic        sck_d = 1'b0;
  logic        awr, wr_, bv, arr, rv, sck, mosi, busy;
  logic [3:0]  awa, ara;
  logic [31:0] wd, rdt;
  logic [31:0] per = 32'h0;
  logic [31:0] lr = 32'h0;
  logic [31:0] cyc = 32'h0;
  logic [1:0]  brs, rrs, wrsp;
  logic [7:0]  st, srx;
  int          n_fail = 0;
  int          n_tests = 0;
  sbr_top sbr_top_inst (.i_sys_clk(clk), .i_arst_n(rst_n),
    .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_awaddr(awa),
    .i_s_axi_wvalid(wv), .o_s_axi_wready(wr_), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hF),
    .o_s_axi_bvalid(bv), .i_s_axi_bready(bry), .o_s_axi_bresp(brs),
    .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ara),
    .o_s_axi_rvalid(rv), .i_s_axi_rready(rry), .o_s_axi_rdata(rdt), .o_s_axi_rresp(rrs),
    .o_sck(sck), .o_mosi(mosi), .i_miso(miso), .o_busy(busy));
  sbr_spi_slave sbr_spi_slave_inst (.i_clk(clk), .i_sck(sck), .i_mosi(mosi),
    .i_busy(busy), .i_tx(st), .o_miso(miso), .o_rx(srx));
  // ==========
  // clock, period monitor, timeout
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 32'h1;
    sck_d <= sck;
    if (sck && !sck_d) begin
      per <= cyc - lr;
      lr <= cyc;
    end
    if (cyc == 32'h0000_EA60) begin
      n_fail++;
      report_and_stop;
    end
  end
  // ==========
  // tasks
  function automatic logic [31:0] hp(input logic [2:0] p, input logic [2:0] r);
    return (32'(p) + 32'h1) << (32'(r) + 32'h1);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic report_and_stop;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ready drops for one edge so no signal is driven twice per step
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= d;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_) wv <= 1'b0;
    end while (!bv);
    wrsp = brs;
    bry <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] e);
    arv <= 1'b1;
    ara <= a;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
    end while (!rv);
    d = rdt;
    e = rrs;
    rry <= 1'b0;
    @(posedge clk);
  endtask
  task automatic go(input logic [2:0] p, input logic [2:0] r, input logic clr);
    logic [31:0] d;
    logic [1:0]  e;
    logic [7:0]  tx;
    tx = 8'($urandom);
    st <= 8'($urandom);
    wr(`SBR_OFS_RATE, {25'h0, p, 1'b0, r});
    wr(`SBR_OFS_DATA, {24'h0, tx});
    wr(`SBR_OFS_RATE, {25'h0, p, 1'b0, r});
    rd(`SBR_OFS_RATE, d, e);
    chk(d, {25'h0, p, 1'b0, r});
    while (busy) @(posedge clk);
    chk(per, hp(p, r));
    chk({24'h0, srx}, {24'h0, tx});
    if (clr) begin
      rd(`SBR_OFS_STATUS, d, e);
      chk(d, 32'h80);
      rd(`SBR_OFS_DATA, d, e);
      chk(d, {24'h0, st});
      rd(`SBR_OFS_STATUS, d, e);
      chk(d, 32'h0);
    end
  endtask
  // ==========
  // main sequence
  initial begin
    logic [31:0] d;
    logic [1:0]  e;
    logic [7:0]  v;
    void'($urandom(32'hEB9B91DE));
    {rst_n, awv, wv, bry, arv, rry, awa, ara, wd, st} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`SBR_OFS_STATUS, d, e);
    chk(d, 32'h0);
    rd(`SBR_OFS_RATE, d, e);
    chk(d, 32'h0);
    rd(4'hC, d, e);
    chk({30'h0, e}, 32'h2);
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom) & 8'h77;
      wr(`SBR_OFS_RATE, {24'h0, v});
      chk({30'h0, wrsp}, 32'h0);
      rd(`SBR_OFS_RATE, d, e);
      chk(d, {24'h0, v});
    end
    for (int i = 0; i < 8; i++) go(3'(i), 3'(7 - i), 1'b1);
    go(3'h7, 3'h7, 1'b1);
    go(3'h0, 3'h1, 1'b0);
    rd(`SBR_OFS_DATA, d, e);
    chk(d, {24'h0, st});
    rd(`SBR_OFS_STATUS, d, e);
    chk(d, 32'h80);
    v = st;
    wr(`SBR_OFS_STATUS, 32'h0);
    chk({30'h0, wrsp}, 32'h0);
    rd(`SBR_OFS_STATUS, d, e);
    chk(d, 32'h80);
    go(3'h0, 3'h1, 1'b0);
    rd(`SBR_OFS_DATA, d, e);
    chk(d, {24'h0, v});
    rd(`SBR_OFS_STATUS, d, e);
    chk(d, 32'h0);
    report_and_stop;
  end
endmodule
`default_nettype wire
